/* shared/itas_pkg.sv */
// package for the two-wire bus timeout and abort-cause status block
// assumes an APB slave at 200 MHz pclk; master/slave engine lies outside
// Function
// - timeout enable bit 0 of timeout register, effective only in master mode
// - enabled timeout: after 256 periods of unready slave, master resets itself
// - start byte acknowledged as master sets abort bit 7
// - 7-bit address unacknowledged as master sets abort bit 0
package itas_pkg;
  localparam logic [7:0] ITAS_OFS_TIMEOUT = 8'h7C;
  localparam logic [7:0] ITAS_OFS_ABORT = 8'h80;
  localparam logic [7:0] ITAS_OFS_IRQ_EN = 8'h84;
  localparam logic [7:0] ITAS_OFS_IRQ_CLR = 8'h88;
  localparam logic [7:0] ITAS_OFS_IRQ_STAT = 8'h8C;
  localparam int ITAS_TIMEOUT_ENABLE_BIT_BIT = 0;
  localparam int ITAS_TIMEOUT_COUNT_VALUE_LSB = 4;
  localparam int ITAS_TIMEOUT_COUNT_VALUE_W = 8;
  localparam int ITAS_TIMEOUT_PERIODS = 256;
  localparam int ITAS_ABORT_W = 16;
  localparam int ITAS_START_BYTE_ACKED_FLAG_BIT = 7;
  localparam int ITAS_7ADR_BIT = 0;
  localparam int ITAS_IRQ_W = 2;
  localparam int ITAS_IRQ_ABORT = 0;
  localparam int ITAS_IRQ_TIMEOUT = 1;
  localparam logic ITAS_TIMEOUT_ENABLE_BIT_RST = 1'b0;
  localparam logic [15:0] ITAS_ABORT_RST = 16'h0000;
endpackage

/* verilog/itas_timeout_cnt.sv */
// counts unready-slave periods and flags expiry
// assumes period_tick is a one-cycle pulse per bus period
module itas_timeout_cnt
  import itas_pkg::*;
#(
  parameter int LIMIT = ITAS_TIMEOUT_PERIODS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic run,
  input wire logic period_tick,
  output logic [ITAS_TIMEOUT_COUNT_VALUE_W-1:0] count,
  output logic expire
);
  typedef struct packed {
    logic [ITAS_TIMEOUT_COUNT_VALUE_W-1:0] cnt;
    logic exp;
  } itas_cnt_t;
  itas_cnt_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.exp = 1'b0;
    if (!run) begin
      nxt_st.cnt = '0;
    end else if (period_tick) begin
      // 8-bit counter wraps from 255 to 0 on the 256th period
      if (st_ff.cnt == ITAS_TIMEOUT_COUNT_VALUE_W'(LIMIT - 1)) begin
        nxt_st.exp = 1'b1;
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.cnt;
  assign expire = st_ff.exp;
endmodule

/* verilog/itas_top.sv */
// APB register block: timeout control, abort causes, interrupt
// assumes the transfer engine pulses abort events synchronous to pclk
//
// Register access over APB was left to the implementer.
module itas_top
  import itas_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_mode,
  input wire logic slave_unready,
  input wire logic period_tick,
  input wire logic [ITAS_ABORT_W-1:0] abort_event,
  output logic master_reset,
  output logic irq
);
  typedef struct packed {
    logic timeout_enable_bit;
    logic [ITAS_ABORT_W-1:0] abort;
    logic [ITAS_IRQ_W-1:0] irq_stat;
    logic [ITAS_IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
    logic mreset;
  } itas_state_t;
  itas_state_t st_ff, nxt_st;

  logic [ITAS_TIMEOUT_COUNT_VALUE_W-1:0] timeout_count_value;
  logic expire;
  logic run;
  logic wr;
  logic rd;
  logic [ITAS_IRQ_W-1:0] irq_evt;

  // only a master waiting on an unready slave counts
  assign run = st_ff.timeout_enable_bit & master_mode & slave_unready;

  itas_timeout_cnt #(
    .LIMIT(ITAS_TIMEOUT_PERIODS)
  ) u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .run(run),
    .period_tick(period_tick),
    .count(timeout_count_value),
    .expire(expire)
  );

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign irq_evt = {expire, |abort_event};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.mreset = expire;
    // clear first, then events, so a same-cycle event wins
    if (wr && paddr == ITAS_OFS_TIMEOUT) begin
      nxt_st.timeout_enable_bit = pwdata[ITAS_TIMEOUT_ENABLE_BIT_BIT];
    end
    if (wr && paddr == ITAS_OFS_ABORT) begin
      // write 0 clears a cause; written ones keep it
      nxt_st.abort = st_ff.abort & pwdata[ITAS_ABORT_W-1:0];
    end
    if (wr && paddr == ITAS_OFS_IRQ_EN) begin
      nxt_st.irq_en = pwdata[ITAS_IRQ_W-1:0];
    end
    if (wr && paddr == ITAS_OFS_IRQ_CLR) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[ITAS_IRQ_W-1:0];
    end
    nxt_st.abort[ITAS_START_BYTE_ACKED_FLAG_BIT] = nxt_st.abort[ITAS_START_BYTE_ACKED_FLAG_BIT] |
      abort_event[ITAS_START_BYTE_ACKED_FLAG_BIT];
    nxt_st.abort[ITAS_7ADR_BIT] = nxt_st.abort[ITAS_7ADR_BIT] |
      abort_event[ITAS_7ADR_BIT];
    nxt_st.abort = nxt_st.abort | abort_event;
    nxt_st.irq_stat = nxt_st.irq_stat | irq_evt;
    nxt_st.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      // reserved bits read zero; software must ignore them anyway
      unique case (paddr)
        ITAS_OFS_TIMEOUT: begin
          nxt_st.rdata[ITAS_TIMEOUT_ENABLE_BIT_BIT] = st_ff.timeout_enable_bit;
          nxt_st.rdata[ITAS_TIMEOUT_COUNT_VALUE_LSB +: ITAS_TIMEOUT_COUNT_VALUE_W] = timeout_count_value;
        end
        ITAS_OFS_ABORT: nxt_st.rdata[ITAS_ABORT_W-1:0] = st_ff.abort;
        ITAS_OFS_IRQ_EN: nxt_st.rdata[ITAS_IRQ_W-1:0] = st_ff.irq_en;
        ITAS_OFS_IRQ_STAT: nxt_st.rdata[ITAS_IRQ_W-1:0] = st_ff.irq_stat;
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{timeout_enable_bit: ITAS_TIMEOUT_ENABLE_BIT_RST, abort: ITAS_ABORT_RST,
                 irq_stat: '0, irq_en: '0, rdata: '0, mreset: 1'b0};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(paddr == ITAS_OFS_TIMEOUT ||
    paddr == ITAS_OFS_ABORT || paddr == ITAS_OFS_IRQ_EN ||
    paddr == ITAS_OFS_IRQ_CLR || paddr == ITAS_OFS_IRQ_STAT);
  assign prdata = rd ? st_ff.rdata : 32'h0000_0000;
  assign master_reset = st_ff.mreset;
  assign irq = |(st_ff.irq_stat & st_ff.irq_en);

  AST_START_BYTE_ACKED_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && abort_event[ITAS_START_BYTE_ACKED_FLAG_BIT] |=> st_ff.abort[ITAS_START_BYTE_ACKED_FLAG_BIT])
    else $error("start byte ack flag not set");
  AST_7ADR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && abort_event[ITAS_7ADR_BIT] |=> st_ff.abort[ITAS_7ADR_BIT])
    else $error("7-bit nack flag not set");
  AST_ABORT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> ((st_ff.abort & $past(abort_event)) == $past(abort_event)))
    else $error("abort cause lost");
  AST_NO_RUN_NO_RESET: assert property (@(posedge pclk)
    disable iff (!presetn)
    !st_ff.timeout_enable_bit && !$past(st_ff.timeout_enable_bit) && !$past(st_ff.timeout_enable_bit, 2)
    |-> !master_reset)
    else $error("timeout fired while disabled");
  AST_RESET_ON_EXPIRE: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && expire |=> master_reset)
    else $error("expiry did not reset master");
  AST_EXPIRE_AT_LIMIT: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(expire) |-> $past(timeout_count_value) == 8'hFF)
    else $error("timeout expired early");
  AST_TIMEOUT_ENABLE_BIT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr && paddr == ITAS_OFS_TIMEOUT
    |=> st_ff.timeout_enable_bit == $past(pwdata[0]))
    else $error("enable write lost");
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == ITAS_OFS_TIMEOUT |-> prdata[31:12] == 20'h0
    && prdata[3:1] == 3'h0)
    else $error("reserved bits not zero");
  COV_START_BYTE_ACKED_FLAG: cover property (@(posedge pclk) abort_event[ITAS_START_BYTE_ACKED_FLAG_BIT]);
  COV_EXPIRE: cover property (@(posedge pclk) expire);
  COV_IRQ: cover property (@(posedge pclk) irq);
  COV_MRESET: cover property (@(posedge pclk) master_reset);
  COV_SLVERR: cover property (@(posedge pclk) pslverr);

  // bus side: zero wait, error only on unmapped access
  AST_PREADY_HIGH: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && penable |-> pready)
    else $error("pready low in access phase");
  AST_NO_ERR_IDLE: assert property (@(posedge pclk)
    disable iff (!presetn)
    !psel |-> !pslverr)
    else $error("error outside a transfer");
  AST_NO_ERR_MAPPED: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && penable && paddr == ITAS_OFS_ABORT |-> !pslverr)
    else $error("error on mapped register");
  AST_PRDATA_IDLE: assert property (@(posedge pclk)
    disable iff (!presetn)
    !rd |-> prdata == 32'h0000_0000)
    else $error("read data outside read access");
  AST_UNMAPPED_RD_ZERO: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_CLR_READS_ZERO: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd && paddr == ITAS_OFS_IRQ_CLR |-> prdata == 32'h0000_0000)
    else $error("clear register readable");
  AST_ABORT_RSVD: assert property (@(posedge pclk)
    disable iff (!presetn)
    rd && paddr == ITAS_OFS_ABORT |-> prdata[31:16] == 16'h0000)
    else $error("abort reserved bits not zero");

  // state is frozen while the enable is low
  AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(st_ff))
    else $error("state moved while frozen");

  // enable bit keeps its value unless written; abort flags can be set by events but drop only when written
  AST_TIMEOUT_ENABLE_BIT_HOLD: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !(wr && paddr == ITAS_OFS_TIMEOUT) |=> $stable(st_ff.timeout_enable_bit))
    else $error("enable bit changed unwritten");
  AST_ABORT_STICKY: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !(wr && paddr == ITAS_OFS_ABORT)
    |=> (st_ff.abort & $past(st_ff.abort)) == $past(st_ff.abort))
    else $error("abort flag dropped unwritten");
  AST_ABORT_CLR: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && wr && paddr == ITAS_OFS_ABORT && pwdata[15:0] == 16'h0000
    && abort_event == '0 |=> st_ff.abort == '0)
    else $error("abort flags not cleared");

  // counter behaviour behind the timeout
  AST_RUN_CLEARS: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !run |=> timeout_count_value == 8'h00)
    else $error("count kept without run");
  AST_COUNT_STEP: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && run && period_tick && timeout_count_value != 8'hFF
    |=> timeout_count_value == $past(timeout_count_value) + 8'h01)
    else $error("count did not step");
  AST_COUNT_HOLD: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && run && !period_tick |=> timeout_count_value == $past(timeout_count_value))
    else $error("count moved without tick");
  AST_EXPIRE_NEEDS_RUN: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(expire) |-> $past(run) && $past(period_tick))
    else $error("expiry without running count");

  // interrupt status and enable
  AST_IRQ_MASKED: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_ff.irq_en == '0 |-> !irq)
    else $error("irq while all masked");
  AST_IRQ_SET_ABORT: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && |abort_event |=> st_ff.irq_stat[ITAS_IRQ_ABORT])
    else $error("abort status not set");
  AST_IRQ_SET_TIMEOUT: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && expire |=> st_ff.irq_stat[ITAS_IRQ_TIMEOUT])
    else $error("timeout status not set");
  AST_IRQ_CLR: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && wr && paddr == ITAS_OFS_IRQ_CLR && pwdata[0]
    && abort_event == '0 |=> !st_ff.irq_stat[ITAS_IRQ_ABORT])
    else $error("abort status not cleared");
  AST_IRQ_EN_WRITE: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && wr && paddr == ITAS_OFS_IRQ_EN
    |=> st_ff.irq_en == $past(pwdata[1:0]))
    else $error("irq enable write lost");
endmodule

/* sim/itas_far_model.sv */
// far-side bus model: role, slave hold-off, period ticks, abort causes
// assumes the bench moves the want_ inputs just after pclk rises
module itas_far_model
  import itas_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want_master,
  input wire logic want_stall,
  input wire logic [ITAS_ABORT_W-1:0] want_abort,
  output logic master_mode,
  output logic slave_unready,
  output logic period_tick,
  output logic [ITAS_ABORT_W-1:0] abort_event
);
  logic [1:0] div_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'h0;
      master_mode <= 1'b0;
      slave_unready <= 1'b0;
      abort_event <= '0;
    end else begin
      div_ff <= div_ff + 2'h1;
      master_mode <= want_master;
      slave_unready <= want_stall;
      abort_event <= want_abort;
    end
  end
  // bus periods only advance while a slave holds off
  assign period_tick = slave_unready && div_ff == 2'h3;
endmodule

/* sim/itas_top_test.sv */
// self-checking bench for the timeout and abort-cause register block
// assumes a zero-wait APB slave and the far-side model beside it
module itas_top_test import itas_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic want_master = 0, want_stall = 0, mm, su, pt, mrst, irq, rdy, slv;
  logic clk_en = 1'b1;
  logic [15:0] want_abort = 16'h0, ae;
  wire logic [31:0] prdata;
  int num_errors = 0, compares = 0, n;
  itas_top u_itas_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(slv),
    .master_mode(mm), .slave_unready(su), .period_tick(pt),
    .abort_event(ae), .master_reset(mrst), .irq(irq));
  itas_far_model u_itas_far_model (.pclk(pclk), .presetn(presetn),
    .want_master(want_master), .want_stall(want_stall),
    .want_abort(want_abort), .master_mode(mm), .slave_unready(su),
    .period_tick(pt), .abort_event(ae));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  // read data is taken at the completing edge, before regs update
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (rdy !== 1'b1);
    rd = prdata;
    err = slv;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic test_regs();
    apb(0, ITAS_OFS_ABORT, 0);
    chk("abort reset", 32'h0, rd);
    apb(1, ITAS_OFS_TIMEOUT, 32'h1);
    apb(0, ITAS_OFS_TIMEOUT, 0);
    chk("enable", 32'h1, rd);
    // a write while frozen must be lost
    clk_en <= 1'b0;
    apb(1, ITAS_OFS_TIMEOUT, 32'h0);
    clk_en <= 1'b1;
    apb(0, ITAS_OFS_TIMEOUT, 0);
    chk("frozen write", 32'h1, rd);
    apb(0, 8'h90, 0);
    chk("unmapped", 32'h1, {rd[31:1], err});
  endtask
  task automatic test_timeout();
    want_stall <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(0, ITAS_OFS_TIMEOUT, 0);
    chk("count slave role", 32'h1, rd);
    n = 0;
    want_master <= 1'b1;
    repeat (1100) begin
      @(negedge pclk);
      if (mrst === 1'b1) break;
      if (mm && su && pt) n++;
    end
    chk("expiry", {1'b1, 31'(ITAS_TIMEOUT_PERIODS)}, {mrst, 31'(n)});
    @(negedge pclk);
    chk("reset pulse", 32'h0, {31'h0, mrst});
    want_stall <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, ITAS_OFS_TIMEOUT, 0);
    chk("count idle", 32'h1, rd);
  endtask
  task automatic test_abort();
    for (int b = 0; b < ITAS_ABORT_W; b++) begin
      want_abort <= 16'h1 << b;
      @(posedge pclk);
      want_abort <= 16'h0;
      repeat (2) @(posedge pclk);
      apb(0, ITAS_OFS_ABORT, 0);
      chk("abort cause", 32'h1 << b, rd);
      apb(1, ITAS_OFS_ABORT, 32'h0);
    end
  endtask
  task automatic test_irq();
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1, ITAS_OFS_IRQ_EN, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1, ITAS_OFS_IRQ_CLR, 32'h1);
    apb(0, ITAS_OFS_IRQ_STAT, 0);
    chk("irq status", 32'h2, {rd[31:1], irq});
    apb(1, ITAS_OFS_IRQ_CLR, 32'h2);
    apb(0, ITAS_OFS_IRQ_STAT, 0);
    chk("irq cleared", 32'h0, rd);
  endtask
  task automatic results();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs();
    test_timeout();
    test_abort();
    test_irq();
    results();
  end
  initial begin
    #50us;
    num_errors++;
    results();
  end
endmodule
